// ===== logic/mdc_diag.sv
// Diagnostics function handler: loopback, counter reads and counter clears.
// ============================================================================
`timescale 1ns/1ps
`default_nettype none

module mdc_diag (
  // Clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  // Decoded request from the frame layer
  input  wire logic                         req_valid_in,
  input  wire logic [7:0]                   req_server_in,
  input  wire logic [7:0]                   req_func_in,
  input  wire logic [15:0]                  req_sub_in,
  input  wire logic [15:0]                  req_data_in,
  // Bus events from the frame layer
  input  wire logic                         ev_good_msg_in,
  input  wire logic                         ev_bad_msg_in,
  input  wire logic                         ev_exc_rsp_in,
  input  wire logic                         ev_server_msg_in,
  input  wire logic                         ev_bcast_msg_in,
  input  wire logic                         ev_busy_msg_in,
  input  wire logic                         ev_overload_in,
  // Configuration change
  input  wire logic                         comm_param_change_in,
  // Response to the frame layer
  output logic                              rsp_valid_out,
  // Response fields
  output logic      [7:0]                   rsp_server_out,
  output logic      [7:0]                   rsp_func_out,
  output logic      [15:0]                  rsp_sub_out,
  output logic      [15:0]                  rsp_data_out,
  output logic                              rsp_exc_out,
  output logic      [7:0]                   rsp_exc_code_out
);
  import mdc_pkg::*;

  // ==========================================================================
  // Request decode
  logic                 req_is_diag;
  logic                 req_unicast;
  logic                 req_bcast;
  logic                 sub_known;
  logic                 data_ok;
  logic                 do_exc;
  logic [7:0]           exc_code;
  logic                 clr_all;
  logic                 clr_ovr;
  logic [MDC_CNT_W-1:0] sel_value;

  logic [MDC_CNT_W-1:0] cnt_value [MDC_NUM_CNT];
  logic [1:0]           cnt_inc   [MDC_NUM_CNT];
  logic                 cnt_clr   [MDC_NUM_CNT];

  // Only diagnostics requests for server numbers 1 to 0x63 are answered.
  // A broadcast is decoded apart: it may clear, but it never answers.
  always_comb begin
    req_is_diag = req_valid_in && (req_func_in == MDC_FUNC_DIAG);
    req_unicast = req_is_diag && (req_server_in >= MDC_SERVER_MIN)
                  && (req_server_in <= MDC_SERVER_MAX);
    req_bcast   = req_is_diag && (req_server_in == MDC_SERVER_BCAST);
  end

  // ==========================================================================
  // Sub-function select
  // Clear sub-functions answer with the echoed data field, which is zero.
  always_comb begin
    sub_known   = 1'b1;
    sel_value   = MDC_CNT_RESET;
    unique case (req_sub_in)
      MDC_SUB_LOOPBACK:   sel_value = req_data_in;
      MDC_SUB_CLEAR_ALL:  sel_value = req_data_in;
      MDC_SUB_GOOD_MSG:   sel_value = cnt_value[MDC_IDX_GOOD];
      MDC_SUB_BAD_MSG:    sel_value = cnt_value[MDC_IDX_BAD];
      MDC_SUB_EXC_RSP:    sel_value = cnt_value[MDC_IDX_EXC];
      MDC_SUB_SERVER_MSG: sel_value = cnt_value[MDC_IDX_SERVER];
      MDC_SUB_BCAST_MSG:  sel_value = cnt_value[MDC_IDX_BCAST];
      MDC_SUB_BUSY_MSG:   sel_value = cnt_value[MDC_IDX_BUSY];
      MDC_SUB_OVERLOAD:   sel_value = cnt_value[MDC_IDX_OVR];
      MDC_SUB_CLEAR_OVR:  sel_value = req_data_in;
      default:            sub_known = 1'b0;
    endcase
  end

  // ==========================================================================
  // Exception decision
  // An unknown code outranks a bad data field when both apply.
  always_comb begin
    // Every sub-function except loopback expects a zero data field.
    data_ok  = (req_sub_in == MDC_SUB_LOOPBACK) || (req_data_in == MDC_DATA_ZERO);
    if (!sub_known) begin
      exc_code = MDC_EXC_ILL_FUNC;
    end else if (!data_ok) begin
      exc_code = MDC_EXC_ILL_DATA;
    end else begin
      exc_code = MDC_EXC_NONE;
    end
    do_exc   = req_unicast && (exc_code != MDC_EXC_NONE);
  end

  // ==========================================================================
  // Clear decision
  // Broadcast clears act without a response.
  // A parameter change clears on every cycle that it is held high.
  always_comb begin
    clr_all  = ((req_unicast || req_bcast) && sub_known && data_ok
                && (req_sub_in == MDC_SUB_CLEAR_ALL))
               || comm_param_change_in;
    clr_ovr  = (req_unicast || req_bcast) && sub_known && data_ok
               && (req_sub_in == MDC_SUB_CLEAR_OVR);
  end

  // ==========================================================================
  // Counter clears
  // Only the overrun counter also answers its own clear sub-function.
  always_comb begin
    for (int i = 0; i < MDC_NUM_CNT; i++) begin
      cnt_clr[i] = clr_all;
    end
    cnt_clr[MDC_IDX_OVR]    = clr_all || clr_ovr;
  end

  // ==========================================================================
  // Counter increments
  // The exception counter can step by two: an outside exception and one of ours.
  always_comb begin
    cnt_inc[MDC_IDX_GOOD]   = {1'b0, ev_good_msg_in};
    cnt_inc[MDC_IDX_BAD]    = {1'b0, ev_bad_msg_in};
    cnt_inc[MDC_IDX_EXC]    = 2'({1'b0, ev_exc_rsp_in} + {1'b0, do_exc});
    cnt_inc[MDC_IDX_SERVER] = {1'b0, ev_server_msg_in};
    cnt_inc[MDC_IDX_BCAST]  = {1'b0, ev_bcast_msg_in};
    cnt_inc[MDC_IDX_BUSY]   = {1'b0, ev_busy_msg_in};
    cnt_inc[MDC_IDX_OVR]    = {1'b0, ev_overload_in};
  end

  // ==========================================================================
  // Counter bank
  // One wrapping counter per slot; the index constants place each one.
  for (genvar g = 0; g < MDC_NUM_CNT; g++) begin : g_cnt
    mdc_counter u_cnt (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .clr_in    (cnt_clr[g]),
      .inc_in    (cnt_inc[g]),
      .count_out (cnt_value[g])
    );
  end

  // ==========================================================================
  // Response register
  logic                 next_rsp_valid;
  logic [7:0]           next_rsp_server;
  logic [7:0]           next_rsp_func;
  logic [15:0]          next_rsp_sub;
  logic [15:0]          next_rsp_data;
  logic                 next_rsp_exc;
  logic [7:0]           next_rsp_exc_code;

  // ==========================================================================
  // Response next value
  // Fields hold their last value between answers; only the strobe is one cycle.
  always_comb begin
    next_rsp_valid    = req_unicast;
    next_rsp_server   = rsp_server_out;
    next_rsp_func     = rsp_func_out;
    next_rsp_sub      = rsp_sub_out;
    next_rsp_data     = rsp_data_out;
    next_rsp_exc      = rsp_exc_out;
    next_rsp_exc_code = rsp_exc_code_out;
    if (req_unicast) begin
      next_rsp_server   = req_server_in;
      next_rsp_sub      = req_sub_in;
      next_rsp_exc      = do_exc;
      next_rsp_exc_code = exc_code;
      // An exception answer flags the function code and carries no data.
      if (do_exc) begin
        next_rsp_func = MDC_FUNC_DIAG | MDC_FUNC_EXC_FLAG;
        next_rsp_data = MDC_DATA_ZERO;
      end else begin
        next_rsp_func = MDC_FUNC_DIAG;
        next_rsp_data = sel_value;
      end
    end
  end

  // ==========================================================================
  // Response flops
  // Reset zeroes every field so that nothing stale is shown after power-up.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rsp_valid_out    <= 1'b0;
      rsp_server_out   <= 8'h00;
      rsp_func_out     <= 8'h00;
      rsp_sub_out      <= 16'h0000;
      rsp_data_out     <= 16'h0000;
      rsp_exc_out      <= 1'b0;
      rsp_exc_code_out <= 8'h00;
    end else begin
      rsp_valid_out    <= next_rsp_valid;
      rsp_server_out   <= next_rsp_server;
      rsp_func_out     <= next_rsp_func;
      rsp_sub_out      <= next_rsp_sub;
      rsp_data_out     <= next_rsp_data;
      rsp_exc_out      <= next_rsp_exc;
      rsp_exc_code_out <= next_rsp_exc_code;
    end
  end

endmodule : mdc_diag

`default_nettype wire

// ===== shared/mdc_pkg.sv
// Constants shared by the diagnostics counter block.
package mdc_pkg;

  // ==========================================================================
  // Frame fields
  localparam logic [7:0]  MDC_FUNC_DIAG       = 8'h08;
  localparam logic [7:0]  MDC_FUNC_EXC_FLAG   = 8'h80;
  localparam logic [7:0]  MDC_SERVER_MIN      = 8'h01;
  localparam logic [7:0]  MDC_SERVER_MAX      = 8'h63;
  localparam logic [7:0]  MDC_SERVER_BCAST    = 8'h00;
  localparam logic [15:0] MDC_DATA_ZERO       = 16'h0000;

  // ==========================================================================
  // Sub-function codes
  localparam logic [15:0] MDC_SUB_LOOPBACK    = 16'h0000;
  localparam logic [15:0] MDC_SUB_CLEAR_ALL   = 16'h000A;
  localparam logic [15:0] MDC_SUB_GOOD_MSG    = 16'h000B;
  localparam logic [15:0] MDC_SUB_BAD_MSG     = 16'h000C;
  localparam logic [15:0] MDC_SUB_EXC_RSP     = 16'h000D;
  localparam logic [15:0] MDC_SUB_SERVER_MSG  = 16'h000E;
  localparam logic [15:0] MDC_SUB_BCAST_MSG   = 16'h000F;
  localparam logic [15:0] MDC_SUB_BUSY_MSG    = 16'h0011;
  localparam logic [15:0] MDC_SUB_OVERLOAD    = 16'h0012;
  localparam logic [15:0] MDC_SUB_CLEAR_OVR   = 16'h0014;

  // ==========================================================================
  // Exception codes
  localparam logic [7:0]  MDC_EXC_NONE        = 8'h00;
  localparam logic [7:0]  MDC_EXC_ILL_FUNC    = 8'h01;
  localparam logic [7:0]  MDC_EXC_ILL_DATA    = 8'h03;

  // ==========================================================================
  // Counter bank layout
  localparam int          MDC_CNT_W           = 16;
  localparam int          MDC_NUM_CNT         = 7;
  localparam logic [15:0] MDC_CNT_RESET       = 16'h0000;
  localparam int          MDC_IDX_GOOD        = 0;
  localparam int          MDC_IDX_BAD         = 1;
  localparam int          MDC_IDX_EXC         = 2;
  localparam int          MDC_IDX_SERVER      = 3;
  localparam int          MDC_IDX_BCAST       = 4;
  localparam int          MDC_IDX_BUSY        = 5;
  localparam int          MDC_IDX_OVR         = 6;

endpackage : mdc_pkg

// ===== logic/mdc_counter.sv
// One 16-bit diagnostic counter that wraps past its maximum and clears on command.
`timescale 1ns/1ps
`default_nettype none

module mdc_counter (
  // Clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  // Control
  input  wire logic                         clr_in,
  input  wire logic [1:0]                   inc_in,
  // Value
  output logic      [mdc_pkg::MDC_CNT_W-1:0] count_out
);
  import mdc_pkg::*;

  logic [MDC_CNT_W-1:0] next_count;

  // ==========================================================================
  // Next value
  // A clear in the same cycle as an event keeps that event in the new count.
  always_comb begin
    if (clr_in) begin
      next_count = {{(MDC_CNT_W-2){1'b0}}, inc_in};
    end else begin
      next_count = MDC_CNT_W'(count_out + {{(MDC_CNT_W-2){1'b0}}, inc_in});
    end
  end

  // ==========================================================================
  // Register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_out <= MDC_CNT_RESET;
    end else begin
      count_out <= next_count;
    end
  end

endmodule : mdc_counter

`default_nettype wire

// ===== tb/mdc_diag_checker.sv
// Concurrent checks on the ports of the diagnostics handler.
`timescale 1ns/1ps
`default_nettype none
module mdc_diag_checker (
  input wire logic        clk_in, rst_in, req_valid_in, comm_param_change_in,
  input wire logic        ev_good_msg_in, ev_bad_msg_in, ev_exc_rsp_in, ev_server_msg_in,
  input wire logic        ev_bcast_msg_in, ev_busy_msg_in, ev_overload_in,
  input wire logic        rsp_valid_out, rsp_exc_out,
  input wire logic [7:0]  req_server_in, req_func_in, rsp_server_out, rsp_func_out,
  input wire logic [7:0]  rsp_exc_code_out,
  input wire logic [15:0] req_sub_in, req_data_in, rsp_sub_out, rsp_data_out
);
  import mdc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence take_s;
    req_valid_in && req_func_in == MDC_FUNC_DIAG && req_server_in != MDC_SERVER_BCAST
      && req_server_in <= MDC_SERVER_MAX;
  endsequence
  sequence read_s(logic [15:0] sub);
    take_s ##0 req_sub_in == sub && req_data_in == MDC_DATA_ZERO;
  endsequence
  rsp_latency_a: assert property (take_s |=> rsp_valid_out)
    else $error("request not answered");
  rsp_cause_a: assert property (rsp_valid_out |-> $past(req_valid_in))
    else $error("answer without request");
  refuse_a: assert property (req_valid_in && (req_func_in != MDC_FUNC_DIAG
    || req_server_in > MDC_SERVER_MAX) |=> !rsp_valid_out) else $error("bad request answered");
  echo_a: assert property (take_s |=> rsp_server_out == $past(req_server_in)
    && rsp_sub_out == $past(req_sub_in)) else $error("echo wrong");
  loop_a: assert property (take_s ##0 req_sub_in == MDC_SUB_LOOPBACK |=>
    rsp_data_out == $past(req_data_in) && !rsp_exc_out) else $error("loopback data lost");
  clr_all_a: assert property (read_s(MDC_SUB_CLEAR_ALL) ##0 !ev_good_msg_in ##1
    read_s(MDC_SUB_GOOD_MSG) |=> rsp_data_out == 16'h0000) else $error("clear all missed");
  clr_ovr_a: assert property (read_s(MDC_SUB_CLEAR_OVR) ##0 !ev_overload_in ##1
    read_s(MDC_SUB_OVERLOAD) |=> rsp_data_out == 16'h0000) else $error("overrun clear missed");
  chg_clr_a: assert property (comm_param_change_in && !ev_good_msg_in ##1
    read_s(MDC_SUB_GOOD_MSG) |=> rsp_data_out == 16'h0000) else $error("param clear missed");
  unk_sub_a: assert property (take_s ##0 req_sub_in == 16'h0013 |=> rsp_exc_out
    && rsp_func_out == 8'h88 && rsp_exc_code_out == MDC_EXC_ILL_FUNC) else $error("no exception");
  bcast_quiet_a: assert property (req_valid_in && req_server_in == MDC_SERVER_BCAST |=>
    !rsp_valid_out) else $error("broadcast answered");
  field_hold_a: assert property (!rsp_valid_out |-> $stable({rsp_server_out, rsp_func_out,
    rsp_sub_out, rsp_data_out, rsp_exc_out, rsp_exc_code_out})) else $error("fields moved");
endmodule : mdc_diag_checker
`default_nettype wire

// ===== tb/mdc_client.sv
// Client and bus traffic model that drives the handler and notes the expected answers.
`timescale 1ns/1ps
`default_nettype none
module mdc_client (
  // Clock
  input  wire logic   clk_in,
  // Request and events
  output logic        req_valid_out,
  output logic [7:0]  req_server_out,
  output logic [7:0]  req_func_out,
  output logic [15:0] req_sub_out,
  output logic [15:0] req_data_out,
  output logic [6:0]  ev_out,
  output logic        chg_out
);
  import mdc_pkg::*;
  logic [15:0] cnt [MDC_NUM_CNT] = '{default: 16'h0000};
  logic [56:0] exp_q [$];
  logic [15:0] subs [MDC_NUM_CNT] = '{MDC_SUB_GOOD_MSG, MDC_SUB_BAD_MSG, MDC_SUB_EXC_RSP,
    MDC_SUB_SERVER_MSG, MDC_SUB_BCAST_MSG, MDC_SUB_BUSY_MSG, MDC_SUB_OVERLOAD};
  initial {req_valid_out, req_server_out, req_func_out, req_sub_out, req_data_out} = '0;
  initial {ev_out, chg_out} = '0;
  // Drives one cycle at the falling edge and updates the counter model behind it.
  task automatic step(input logic v, input logic [7:0] s, f, input logic [15:0] sb, d,
                      input logic [6:0] e, input logic c);
    logic ok, hit, known, good, exc, clr_all, clr_ovr;
    logic [15:0] val;
    int k;
    @(negedge clk_in);
    {req_valid_out, req_server_out, req_func_out, req_sub_out, req_data_out} = {v, s, f, sb, d};
    {ev_out, chg_out} = {e, c};
    ok = v && f == MDC_FUNC_DIAG && s <= MDC_SERVER_MAX;
    hit = 1'b0;
    k = 0;
    foreach (subs[i]) if (sb == subs[i]) {hit, k} = {1'b1, i};
    known = hit || sb inside {MDC_SUB_LOOPBACK, MDC_SUB_CLEAR_ALL, MDC_SUB_CLEAR_OVR};
    good = known && (d == MDC_DATA_ZERO || sb == MDC_SUB_LOOPBACK);
    clr_all = ok && good && sb == MDC_SUB_CLEAR_ALL || c;
    clr_ovr = ok && good && sb == MDC_SUB_CLEAR_OVR;
    exc = ok && s != MDC_SERVER_BCAST && !good;
    val = exc ? 16'h0000 : hit ? cnt[k] : d;
    if (ok && s != MDC_SERVER_BCAST) exp_q.push_back({s, exc ? 8'h88 : f, sb, val, exc,
      exc ? (known ? MDC_EXC_ILL_DATA : MDC_EXC_ILL_FUNC) : MDC_EXC_NONE});
    foreach (cnt[i]) cnt[i] = (clr_all || clr_ovr && i == MDC_IDX_OVR ? 16'h0000 : cnt[i])
      + e[i] + (exc && i == MDC_IDX_EXC);
  endtask : step
  task automatic rq(input logic [7:0] s, f, input logic [15:0] sb, d);
    step(1'b1, s, f, sb, d, 7'h00, 1'b0);
  endtask : rq
  task automatic pe(input logic [6:0] e, input logic c);
    step(1'b0, 8'h00, 8'h00, 16'h0000, 16'h0000, e, c);
  endtask : pe
endmodule : mdc_client
`default_nettype wire

// ===== tb/mdc_diag_tb.sv
// Top testbench for the diagnostics handler.
`timescale 1ns/1ps
`default_nettype none
module mdc_diag_tb;
  import mdc_pkg::*;
  logic        clk_in, rst_in, req_valid_in, rsp_valid_out, rsp_exc_out, comm_param_change_in;
  logic [7:0]  req_server_in, req_func_in, rsp_server_out, rsp_func_out, rsp_exc_code_out;
  logic [15:0] req_sub_in, req_data_in, rsp_sub_out, rsp_data_out;
  logic [6:0]  ev;
  logic [56:0] exp_v, got_v;
  int          n_mismatch = 0, comparisons = 0, cycles = 0;
  mdc_client u_cli (.clk_in, .req_valid_out(req_valid_in), .req_server_out(req_server_in),
    .req_func_out(req_func_in), .req_sub_out(req_sub_in), .req_data_out(req_data_in),
    .ev_out(ev), .chg_out(comm_param_change_in));
  mdc_diag u_dut (.clk_in, .rst_in, .req_valid_in, .req_server_in, .req_func_in, .req_sub_in,
    .req_data_in, .ev_good_msg_in(ev[0]), .ev_bad_msg_in(ev[1]), .ev_exc_rsp_in(ev[2]),
    .ev_server_msg_in(ev[3]), .ev_bcast_msg_in(ev[4]), .ev_busy_msg_in(ev[5]),
    .ev_overload_in(ev[6]), .comm_param_change_in, .rsp_valid_out, .rsp_server_out,
    .rsp_func_out, .rsp_sub_out, .rsp_data_out, .rsp_exc_out, .rsp_exc_code_out);
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic close_out;
    $display("compared %0d, mismatched %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic read_all(input logic [7:0] s);
    foreach (u_cli.subs[i]) u_cli.rq(s, MDC_FUNC_DIAG, u_cli.subs[i], 16'h0000);
  endtask : read_all
  // Takes the oldest expected answer whenever the handler answers.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 80000) begin
      n_mismatch++;
      close_out();
    end
    #1;
    if (rsp_valid_out === 1'b1) begin
      comparisons++;
      exp_v = u_cli.exp_q.size() > 0 ? u_cli.exp_q.pop_front() : 'x;
      got_v = {rsp_server_out, rsp_func_out, rsp_sub_out, rsp_data_out, rsp_exc_out,
        rsp_exc_code_out};
      if (got_v !== exp_v) begin
        n_mismatch++;
        $display("[FAIL] response expected %h seen %h", exp_v, got_v);
      end
    end
  end
  initial begin
    rst_in = 1'b1;
    void'($urandom(32'h158A62CA));
    repeat (8) @(posedge clk_in);
    @(negedge clk_in) rst_in = 1'b0;
    read_all(8'h01);
    repeat (4) u_cli.rq(8'($urandom_range(99, 1)), MDC_FUNC_DIAG, 16'h0000, 16'($urandom));
    $display("test reset and loopback done");
    repeat (60) u_cli.pe(7'($urandom), 1'b0);
    read_all(8'h63);
    $display("test counter reads done");
    u_cli.rq(8'h07, MDC_FUNC_DIAG, 16'h0013, 16'h0000);
    u_cli.rq(8'h07, MDC_FUNC_DIAG, MDC_SUB_GOOD_MSG, 16'h0001);
    u_cli.rq(8'h07, MDC_FUNC_DIAG, MDC_SUB_CLEAR_ALL, 16'h0001);
    u_cli.rq(8'h07, 8'h03, MDC_SUB_GOOD_MSG, 16'h0000);
    u_cli.rq(8'h64, MDC_FUNC_DIAG, MDC_SUB_GOOD_MSG, 16'h0000);
    u_cli.rq(8'h07, MDC_FUNC_DIAG, MDC_SUB_EXC_RSP, 16'h0000);
    $display("test exceptions done");
    u_cli.pe(7'h7F, 1'b0);
    u_cli.rq(8'h02, MDC_FUNC_DIAG, MDC_SUB_CLEAR_OVR, 16'h0000);
    u_cli.rq(8'h02, MDC_FUNC_DIAG, MDC_SUB_OVERLOAD, 16'h0000);
    read_all(8'h02);
    u_cli.pe(7'h7F, 1'b0);
    u_cli.pe(7'h00, 1'b1);
    read_all(8'h03);
    u_cli.pe(7'h7F, 1'b0);
    u_cli.rq(8'h01, MDC_FUNC_DIAG, MDC_SUB_CLEAR_ALL, 16'h0000);
    read_all(8'h01);
    u_cli.pe(7'h7F, 1'b0);
    u_cli.rq(MDC_SERVER_BCAST, MDC_FUNC_DIAG, MDC_SUB_CLEAR_ALL, 16'h0000);
    read_all(8'h01);
    $display("test clears done");
    repeat (65535) u_cli.pe(7'h10, 1'b0);
    u_cli.rq(8'h01, MDC_FUNC_DIAG, MDC_SUB_BCAST_MSG, 16'h0000);
    u_cli.pe(7'h10, 1'b0);
    u_cli.rq(8'h01, MDC_FUNC_DIAG, MDC_SUB_BCAST_MSG, 16'h0000);
    u_cli.pe(7'h00, 1'b0);
    repeat (3) @(posedge clk_in);
    $display("test wrap done");
    comparisons++;
    if (u_cli.exp_q.size() != 0) begin
      n_mismatch++;
      $display("[FAIL] pending answers expected 0 seen %0d", u_cli.exp_q.size());
    end
    close_out();
  end
endmodule : mdc_diag_tb
bind mdc_diag mdc_diag_checker u_chk (.clk_in, .rst_in, .req_valid_in, .comm_param_change_in,
  .ev_good_msg_in, .ev_bad_msg_in, .ev_exc_rsp_in, .ev_server_msg_in, .ev_bcast_msg_in,
  .ev_busy_msg_in, .ev_overload_in, .rsp_valid_out, .rsp_exc_out, .req_server_in, .req_func_in,
  .rsp_server_out, .rsp_func_out, .rsp_exc_code_out, .req_sub_in, .req_data_in, .rsp_sub_out,
  .rsp_data_out);
`default_nettype wire
